// ---- common/tiofs_pkg.sv ----
// Package: constants for the timer I/O function select block.
// Assumes: shared by the function-select top and its per-register slice.
package tiofs_pkg;
    localparam int          FUNC_W        = 4;
    localparam int          CNT_W         = 16;
    localparam int          BIT_CAPTURE   = 3;
    localparam int          BIT_LEVEL     = 2;
    localparam int          BIT_BOTH      = 1;
    localparam int          BIT_LOW       = 0;
    localparam logic [3:0]  FUNC_RESET    = 4'h0;
    localparam logic [1:0]  OC_DISABLED   = 2'h0;
    localparam logic [1:0]  OC_CLEAR      = 2'h1;
    localparam logic [1:0]  OC_SET        = 2'h2;
    localparam logic [1:0]  OC_TOGGLE     = 2'h3;
    localparam logic [15:0] REG_RESET     = 16'hFFFF;
endpackage : tiofs_pkg

// ---- hdl/tiofs_slice.sv ----
// One general register with its function field and pin logic.
// Assumes: counter and pin samples are synchronous to clock_i.
`timescale 1ns/10ps
module tiofs_slice
    import tiofs_pkg::*;
#(
    parameter int CNT_W_P = CNT_W
)
(
    // Clock and reset
    input  wire logic               clock_i,
    input  wire logic               reset_n_i,
    // Configuration
    input  wire logic [FUNC_W-1:0]  func_i,
    input  wire logic               inhibit_i,
    input  wire logic               neighbour_ev_i,
    // Counter and software write
    input  wire logic [CNT_W_P-1:0] counter_i,
    input  wire logic               reg_wr_i,
    input  wire logic [CNT_W_P-1:0] reg_wdata_i,
    // Pin
    input  wire logic               pin_i,
    output logic                    pin_o,
    output logic                    pin_oe_o,
    // Results
    output logic [CNT_W_P-1:0]      reg_o,
    output logic                    event_o
);
    logic               pin_d_r;
    logic               is_cap;
    logic               rise;
    logic               fall;
    logic               cap_ev;
    logic               match_ev;
    logic [1:0]         oc_mode;
    logic [FUNC_W-1:0]  func_d_r;

    // Reset value is only defined up to the package counter width
    if (CNT_W_P < 1 || CNT_W_P > CNT_W)
    begin : g_bad_width_s
        $error("tiofs_slice: counter width out of range");
    end

    assign is_cap  = func_i[BIT_CAPTURE];
    assign oc_mode = func_i[1:0];
    assign rise    = pin_i & ~pin_d_r;
    assign fall    = ~pin_i & pin_d_r;

    always_comb
    begin
        cap_ev = 1'b0;
        if (is_cap && !inhibit_i)
        begin
            if (func_i[BIT_LEVEL])
                cap_ev = neighbour_ev_i;
            else if (func_i[BIT_BOTH])
                cap_ev = rise | fall;
            else if (func_i[BIT_LOW])
                cap_ev = fall;
            else
                cap_ev = rise;
        end
    end

    // Match only counts while the register is a compare register
    assign match_ev = !is_cap && !inhibit_i && (counter_i == reg_o);
    assign event_o  = cap_ev | match_ev;

    // Sampled through reset so a high idle pin gives no false edge
    always_ff @(posedge clock_i)
    begin
        pin_d_r <= pin_i;
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
            reg_o <= REG_RESET[CNT_W_P-1:0];
        else if (cap_ev)
            reg_o <= counter_i;
        else if (reg_wr_i)
            reg_o <= reg_wdata_i;
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
            func_d_r <= FUNC_RESET;
        else
            func_d_r <= func_i;
    end

    // Initial level reloads whenever the field changes
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            pin_o    <= 1'b0;
            pin_oe_o <= 1'b0;
        end
        else if (is_cap || oc_mode == OC_DISABLED || inhibit_i)
        begin
            pin_oe_o <= 1'b0;
            pin_o    <= func_i[BIT_LEVEL];
        end
        else if (func_i != func_d_r || !pin_oe_o)
        begin
            pin_oe_o <= 1'b1;
            pin_o    <= func_i[BIT_LEVEL];
        end
        else if (match_ev)
        begin
            unique case (oc_mode)
                OC_CLEAR:  pin_o <= 1'b0;
                OC_SET:    pin_o <= 1'b1;
                OC_TOGGLE: pin_o <= ~pin_o;
                default:   pin_o <= pin_o;
            endcase
        end
    end
endmodule : tiofs_slice

// ---- hdl/tiofs_top.sv ----
// Overview of operation
// - Bits 3:0 select register A function
// - Separate field selects register C function
// - Top bit 0: compare, bit2 initial level
// - Low bits 01: pin low at match
// - Low bits 10: pin high at match
// - Low bits 11: toggle pin at match
// - Capture mode 00: capture on rising edge
// - Capture mode 01: capture on falling edge
// - Bit 1 set: capture on both edges
// - Channel 0 bit2: capture on channel 1 count
// - Channel 1 bit2: capture on channel 0 A event
// - Buffer mode suppresses register C function
// Assumes: counters, count enable and pins are synchronous to clock_i.
`timescale 1ns/10ps
module tiofs_top
    import tiofs_pkg::*;
#(
    parameter int CNT_W_P = CNT_W
)
(
    // Clock and reset
    input  wire logic               clock_i,
    input  wire logic               reset_n_i,
    // Control field writes
    input  wire logic               ch0_a_func_wr_i,
    input  wire logic               ch0_c_func_wr_i,
    input  wire logic               ch1_a_func_wr_i,
    input  wire logic [FUNC_W-1:0]  func_wdata_i,
    input  wire logic               buffer_mode_a_i,
    // Counters
    input  wire logic [CNT_W_P-1:0] ch0_counter_i,
    input  wire logic [CNT_W_P-1:0] ch1_counter_i,
    input  wire logic               ch1_count_en_i,
    // General register writes
    input  wire logic               ch0_a_reg_wr_i,
    input  wire logic               ch0_c_reg_wr_i,
    input  wire logic               ch1_a_reg_wr_i,
    input  wire logic [CNT_W_P-1:0] reg_wdata_i,
    // Pins
    input  wire logic               ch0_pin_a_i,
    output logic                    ch0_pin_a_o,
    output logic                    ch0_pin_a_oe_o,
    input  wire logic               ch0_pin_c_i,
    output logic                    ch0_pin_c_o,
    output logic                    ch0_pin_c_oe_o,
    input  wire logic               ch1_pin_a_i,
    output logic                    ch1_pin_a_o,
    output logic                    ch1_pin_a_oe_o,
    // Status
    output logic [FUNC_W-1:0]       ch0_a_func_o,
    output logic [FUNC_W-1:0]       ch0_c_func_o,
    output logic [FUNC_W-1:0]       ch1_a_func_o,
    output logic [CNT_W_P-1:0]      ch0_general_reg_a_o,
    output logic [CNT_W_P-1:0]      ch0_general_reg_c_o,
    output logic [CNT_W_P-1:0]      ch1_general_reg_a_o,
    output logic                    ch0_a_event_o,
    output logic                    ch0_c_event_o,
    output logic                    ch1_a_event_o
);
    logic [FUNC_W-1:0] ch1_a_eff;

    // Register reset value is only defined up to the package width
    if (CNT_W_P < 1 || CNT_W_P > CNT_W)
    begin : g_bad_width
        $error("tiofs_top: counter width out of range");
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            ch0_a_func_o <= FUNC_RESET;
            ch0_c_func_o <= FUNC_RESET;
            ch1_a_func_o <= FUNC_RESET;
        end
        else
        begin
            if (ch0_a_func_wr_i)
                ch0_a_func_o <= func_wdata_i;
            if (ch0_c_func_wr_i)
                ch0_c_func_o <= func_wdata_i;
            if (ch1_a_func_wr_i)
                ch1_a_func_o <= func_wdata_i;
        end
    end

    // Channel 1 has no count-clock source; only the channel 0 event path
    assign ch1_a_eff = ch1_a_func_o;

    tiofs_slice #(.CNT_W_P(CNT_W_P)) u_ch0_a
    (
        .clock_i        (clock_i),
        .reset_n_i      (reset_n_i),
        .func_i         (ch0_a_func_o),
        .inhibit_i      (1'b0),
        .neighbour_ev_i (ch1_count_en_i),
        .counter_i      (ch0_counter_i),
        .reg_wr_i       (ch0_a_reg_wr_i),
        .reg_wdata_i    (reg_wdata_i),
        .pin_i          (ch0_pin_a_i),
        .pin_o          (ch0_pin_a_o),
        .pin_oe_o       (ch0_pin_a_oe_o),
        .reg_o          (ch0_general_reg_a_o),
        .event_o        (ch0_a_event_o)
    );

    tiofs_slice #(.CNT_W_P(CNT_W_P)) u_ch0_c
    (
        .clock_i        (clock_i),
        .reset_n_i      (reset_n_i),
        .func_i         (ch0_c_func_o),
        .inhibit_i      (buffer_mode_a_i),
        .neighbour_ev_i (ch1_count_en_i),
        .counter_i      (ch0_counter_i),
        .reg_wr_i       (ch0_c_reg_wr_i),
        .reg_wdata_i    (reg_wdata_i),
        .pin_i          (ch0_pin_c_i),
        .pin_o          (ch0_pin_c_o),
        .pin_oe_o       (ch0_pin_c_oe_o),
        .reg_o          (ch0_general_reg_c_o),
        .event_o        (ch0_c_event_o)
    );

    tiofs_slice #(.CNT_W_P(CNT_W_P)) u_ch1_a
    (
        .clock_i        (clock_i),
        .reset_n_i      (reset_n_i),
        .func_i         (ch1_a_eff),
        .inhibit_i      (1'b0),
        .neighbour_ev_i (ch0_a_event_o),
        .counter_i      (ch1_counter_i),
        .reg_wr_i       (ch1_a_reg_wr_i),
        .reg_wdata_i    (reg_wdata_i),
        .pin_i          (ch1_pin_a_i),
        .pin_o          (ch1_pin_a_o),
        .pin_oe_o       (ch1_pin_a_oe_o),
        .reg_o          (ch1_general_reg_a_o),
        .event_o        (ch1_a_event_o)
    );
endmodule : tiofs_top

// ---- verif/tiofs_pins.sv ----
// Pin model: outside levels with the block's own drivers resolved.
// Assumes: the outside source is weaker than an enabled block driver.
`timescale 1ns/10ps
module tiofs_pins
(
    // Outside levels and block drive
    input  wire logic [2:0] lvl_i,
    input  wire logic [2:0] dout_i,
    input  wire logic [2:0] oe_i,
    // Resolved wires
    output logic      [2:0] pin_o
);
    assign pin_o = (oe_i & dout_i) | (~oe_i & lvl_i);
endmodule : tiofs_pins

// ---- verif/tiofs_asserts.sv ----
// Checker: timing relations at the function-select top ports.
// Assumes: bound into tiofs_top, single clock domain.
`timescale 1ns/10ps
module tiofs_asserts
    import tiofs_pkg::*;
#(parameter int CNT_W_P = CNT_W)
(
    input wire logic clock_i, reset_n_i, ch0_a_func_wr_i, buffer_mode_a_i,
    input wire logic ch1_count_en_i, ch0_pin_a_i, ch0_pin_a_o, ch0_pin_c_oe_o,
    input wire logic ch0_a_event_o, ch0_c_event_o, ch1_a_event_o,
    input wire logic [FUNC_W-1:0] func_wdata_i, ch0_a_func_o, ch0_c_func_o, ch1_a_func_o,
    input wire logic [CNT_W_P-1:0] ch0_counter_i, ch0_general_reg_a_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    // The cycle after a field change reloads the initial level instead
    logic oc_hit;
    assign oc_hit = ch0_a_event_o && !ch0_a_func_o[3];
    func_a_wr_a: assert property (
        ch0_a_func_wr_i |=> ch0_a_func_o == $past(func_wdata_i)) else $error("field A lost");
    oc_clear_a: assert property (
        oc_hit && $stable(ch0_a_func_o) && ch0_a_func_o[1:0] == 2'h1 |=> !ch0_pin_a_o)
        else $error("pin not cleared");
    oc_toggle_a: assert property (
        oc_hit && $stable(ch0_a_func_o) && ch0_a_func_o[1:0] == 2'h3
        |=> ch0_pin_a_o != $past(ch0_pin_a_o))
        else $error("pin not toggled");
    cap_rise_a: assert property (
        ch0_a_func_o == 4'h8 && !ch0_a_func_wr_i && $rose(ch0_pin_a_i) |-> ch0_a_event_o
        ##1 ch0_general_reg_a_o == $past(ch0_counter_i)) else $error("rise not captured");
    cap_both_a: assert property (
        ch0_a_func_o[3:1] == 3'h5 && $changed(ch0_pin_a_i) |-> ch0_a_event_o)
        else $error("edge missed");
    cap_count_a: assert property (
        ch0_a_func_o[3:2] == 2'h3 && ch1_count_en_i |-> ch0_a_event_o) else $error("count missed");
    cap_chain_a: assert property (
        ch1_a_func_o[3:2] == 2'h3 && ch0_a_event_o |-> ch1_a_event_o) else $error("chain missed");
    buf_block_a: assert property (
        buffer_mode_a_i [*2] |-> !ch0_c_event_o && !ch0_pin_c_oe_o) else $error("C active");
    reset_val_a: assert property (
        $rose(reset_n_i) |-> {ch0_a_func_o, ch0_c_func_o, ch1_a_func_o} == 12'h000)
        else $error("fields not cleared");
endmodule : tiofs_asserts
bind tiofs_top tiofs_asserts #(.CNT_W_P(CNT_W_P)) u_chk (.*);

// ---- verif/tb_top.sv ----
// Testbench: drives field writes, counters and pins, checks results.
// Assumes: the pin model resolves the three timer pins.
`timescale 1ns/10ps
module tb_top;
    import tiofs_pkg::*;
    logic        clock_i = 1'h0, reset_n_i = 1'h0, buffer_mode_a_i = 1'h0, ch1_count_en_i = 1'h0;
    logic [5:0]  wr_s = '0;
    logic [2:0]  lvl = '0;
    logic [3:0]  func_wdata_i = '0, ch0_a_func_o, ch0_c_func_o, ch1_a_func_o;
    logic [15:0] ch0_counter_i = '0, ch1_counter_i = '0, reg_wdata_i = '0;
    logic [15:0] ch0_general_reg_a_o, ch0_general_reg_c_o, ch1_general_reg_a_o;
    logic        ch0_a_func_wr_i, ch0_c_func_wr_i, ch1_a_func_wr_i, ch0_a_reg_wr_i;
    logic        ch0_c_reg_wr_i, ch1_a_reg_wr_i, ch0_pin_a_i, ch0_pin_a_o, ch0_pin_a_oe_o;
    logic        ch0_pin_c_i, ch0_pin_c_o, ch0_pin_c_oe_o, ch1_pin_a_i, ch1_pin_a_o;
    logic        ch1_pin_a_oe_o, ch0_a_event_o, ch0_c_event_o, ch1_a_event_o;
    int          err_count = 0, n_checks = 0;
    assign {ch1_a_reg_wr_i, ch0_c_reg_wr_i, ch0_a_reg_wr_i} = wr_s[5:3];
    assign {ch1_a_func_wr_i, ch0_c_func_wr_i, ch0_a_func_wr_i} = wr_s[2:0];
    tiofs_top dut (.*);
    tiofs_pins u_pins (
        .lvl_i  (lvl),
        .dout_i ({ch1_pin_a_o, ch0_pin_c_o, ch0_pin_a_o}),
        .oe_i   ({ch1_pin_a_oe_o, ch0_pin_c_oe_o, ch0_pin_a_oe_o}),
        .pin_o  ({ch1_pin_a_i, ch0_pin_c_i, ch0_pin_a_i})
    );
    task automatic chk(string nm, logic [15:0] ex, logic [15:0] got);
        n_checks++;
        if (got !== ex)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    // One strobe cycle; s picks register and field strobes together
    task automatic wr(logic [5:0] s, logic [15:0] v);
        @(posedge clock_i);
        wr_s <= s;
        func_wdata_i <= v[3:0];
        reg_wdata_i <= v;
        @(posedge clock_i);
        wr_s <= '0;
    endtask : wr
    task automatic t_oc();
        for (int m = 1; m < 8; m++)
        begin
            wr(6'h08, 16'h0010);
            wr(6'h01, m[15:0]);
            @(posedge clock_i);
            #1;
            chk("func a", m[15:0], ch0_a_func_o);
            chk("oe", m[1:0] != 2'h0, ch0_pin_a_oe_o);
            if (m[1:0] != 2'h0)
                chk("init", m[2], ch0_pin_a_o);
            @(posedge clock_i) ch0_counter_i <= 16'h0010;
            @(posedge clock_i) ch0_counter_i <= 16'h0000;
            #1;
            if (m[1:0] != 2'h0)
                chk("match", (m[1:0] == 2'h3) ? !m[2] : m[1], ch0_pin_a_o);
        end
    endtask : t_oc
    task automatic t_cap();
        for (int m = 8; m < 12; m++)
        begin
            wr(6'h08, 16'h0000);
            wr(6'h01, m[15:0]);
            @(posedge clock_i) {ch0_counter_i, lvl[0]} <= {16'h0021, 1'h1};
            @(posedge clock_i) {ch0_counter_i, lvl[0]} <= {16'h0042, 1'h0};
            #1;
            chk("rise", (m != 9) ? 16'h0021 : 16'h0000, ch0_general_reg_a_o);
            @(posedge clock_i);
            #1;
            chk("fall", (m == 8) ? 16'h0021 : 16'h0042, ch0_general_reg_a_o);
        end
    endtask : t_cap
    task automatic t_nb();
        wr(6'h01, 16'h000C);
        wr(6'h04, 16'h000C);
        @(posedge clock_i) {ch0_counter_i, ch1_counter_i, ch1_count_en_i} <= {16'h0055, 16'h0077, 1'h1};
        @(posedge clock_i) ch1_count_en_i <= 1'h0;
        #1;
        chk("count", 16'h0055, ch0_general_reg_a_o);
        chk("chain", 16'h0077, ch1_general_reg_a_o);
        wr(6'h02, 16'h0008);
        #1;
        chk("func c", 16'h0008, ch0_c_func_o);
        @(posedge clock_i) {buffer_mode_a_i, lvl[1]} <= 2'h3;
        @(posedge clock_i) lvl[1] <= 1'h0;
        #1;
        chk("buffered", REG_RESET, ch0_general_reg_c_o);
        @(posedge clock_i) {buffer_mode_a_i, lvl[1]} <= 2'h1;
        @(posedge clock_i);
        #1;
        chk("cap c", 16'h0055, ch0_general_reg_c_o);
    endtask : t_nb
    // Compare use on C and channel 1 A, C buffered for a while
    task automatic t_cmp();
        wr(6'h36, 16'h0003);
        #1;
        chk("reg c wr", 16'h0003, ch0_general_reg_c_o);
        chk("reg 1a wr", 16'h0003, ch1_general_reg_a_o);
        @(posedge clock_i);
        #1;
        chk("oe 1a", 16'h0001, ch1_pin_a_oe_o);
        chk("init 1a", 16'h0000, ch1_pin_a_o);
        @(posedge clock_i);
        ch0_counter_i <= 16'h0003;
        ch1_counter_i <= 16'h0003;
        buffer_mode_a_i <= 1'h1;
        @(posedge clock_i) ch1_counter_i <= 16'h0000;
        @(posedge clock_i) ch0_counter_i <= 16'h0000;
        #1;
        chk("toggle 1a", 16'h0001, ch1_pin_a_o);
        chk("buffered oe", 16'h0000, ch0_pin_c_oe_o);
        @(posedge clock_i) buffer_mode_a_i <= 1'h0;
        @(posedge clock_i) ch0_counter_i <= 16'h0003;
        @(posedge clock_i) ch0_counter_i <= 16'h0000;
        #1;
        chk("oe c", 16'h0001, ch0_pin_c_oe_o);
        chk("toggle c", 16'h0001, ch0_pin_c_o);
    endtask : t_cmp
    task automatic results();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    initial
    begin
        forever #2 clock_i = ~clock_i;
    end
    initial
    begin
        repeat (2) @(posedge clock_i);
        reset_n_i <= 1'h1;
        @(posedge clock_i);
        #1;
        chk("fields", 16'h0000, {ch0_a_func_o, ch0_c_func_o, ch1_a_func_o});
        chk("reg", REG_RESET, ch1_general_reg_a_o);
        t_oc();
        t_cap();
        t_nb();
        t_cmp();
        results();
    end
    // Whole run is about a hundred cycles
    initial
    begin
        #20000;
        err_count++;
        results();
    end
endmodule : tb_top
